//--- logic/sso_pkg.sv
// Package for the status output selector: function codes, reset values,
// status carrier struct and timing constants.
// Assumes a single 50 MHz system clock shared by every user of the package.
package sso_pkg;

    // Width of one function select register
    localparam int unsigned SEL_W = 8;
    // Number of condition slots addressed by the low code bits
    localparam int unsigned COND_N = 64;

    // Function codes
    localparam logic [SEL_W-1:0] FN_RUN    = 8'h00;
    localparam logic [SEL_W-1:0] FN_ZERO   = 8'h01;
    localparam logic [SEL_W-1:0] FN_READY  = 8'h06;
    localparam logic [SEL_W-1:0] FN_UNDERV = 8'h07;
    localparam logic [SEL_W-1:0] FN_BLOCK  = 8'h08;
    localparam logic [SEL_W-1:0] FN_REFSRC = 8'h09;
    localparam logic [SEL_W-1:0] FN_RUNSRC = 8'h0A;
    localparam logic [SEL_W-1:0] FN_FAULT  = 8'h0E;
    localparam logic [SEL_W-1:0] FN_ALARM  = 8'h10;
    localparam logic [SEL_W-1:0] FN_FRESET = 8'h11;
    localparam logic [SEL_W-1:0] FN_REV    = 8'h1A;
    localparam logic [SEL_W-1:0] FN_OHPRE  = 8'h20;
    localparam logic [SEL_W-1:0] FN_RUN2   = 8'h37;
    localparam logic [SEL_W-1:0] FN_ENA    = 8'h38;
    localparam logic [SEL_W-1:0] FN_WAIT   = 8'h39;
    localparam logic [SEL_W-1:0] FN_OHRED  = 8'h3A;
    localparam logic [SEL_W-1:0] FN_NETRUN = 8'h3B;
    localparam logic [SEL_W-1:0] FN_FAN    = 8'h3D;
    // Highest accepted code
    localparam logic [SEL_W-1:0] FN_MAX    = 8'h3D;

    // Reset values of the two select registers
    localparam logic [SEL_W-1:0] RST_SEL_A = 8'h00;
    localparam logic [SEL_W-1:0] RST_SEL_B = 8'h01;

    // Heatsink trip level in degrees Celsius
    localparam logic [7:0] OH_TRIP_DEGC = 8'h69;

    // Clock period and run delay time base
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned DELAY_TICK_NS = 1000000;
    localparam int unsigned TICK_CYCLES   = DELAY_TICK_NS / CLK_PERIOD_NS;

    // Run-wait timer states
    typedef enum logic [1:0] {
        SSO_IDLE = 2'b00,
        SSO_WAIT = 2'b01,
        SSO_DONE = 2'b10
    } sso_wait_e;

    // Drive status conditions gathered from the rest of the controller
    typedef struct packed {
        logic runCmd;        // Run command active
        logic outVoltage;    // Power stage producing voltage
        logic dcInject;      // DC injection braking in progress
        logic outBlocked;    // Power stage blocked
        logic initDone;      // Startup initialisation finished
        logic faultAny;      // Any fault present
        logic commFaultA;    // ctrl_comm_fault_a present
        logic commFaultB;    // ctrl_comm_fault_b present
        logic alarm;         // Minor fault condition
        logic underVolt;     // DC bus undervoltage detected
        logic keypadRefSel;  // Keypad is frequency reference source
        logic keypadRunSel;  // Keypad is run command source
        logic faultResetIn;  // Fault reset asserted on a digital input
        logic reverse;       // Motor turning in reverse
        logic enabled;       // Drive enabled by digital input
        logic reducedFreq;   // Running at overheat_reduced_frequency
        logic serialRun;     // Run from built-in serial port
        logic optionRun;     // Run from option card
        logic fanFault;      // Cooling fan faulty
    } sso_status_s;

    // True when a code lies in the accepted range
    function automatic logic ssoCodeOk(input logic [SEL_W-1:0] code);
        ssoCodeOk = (code <= FN_MAX);
    endfunction : ssoCodeOk

endpackage : sso_pkg

//--- logic/sso_out_select.sv
// One output terminal pair: picks a condition by function code and
// registers it. Assumes the code never exceeds the condition vector size.
module sso_out_select
    import sso_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic [sso_pkg::SEL_W-1:0] funcSel,
    input  wire logic [sso_pkg::COND_N-1:0] condVec,
    output logic                         termOn
);
    import sso_pkg::*;

    logic termOn_d;  // Next contact state

    // Selection; unused code slots carry zero so the contact opens
    always_comb
    begin
        termOn_d = condVec[funcSel[5:0]];
    end

    // Registered contact keeps external equipment free of decode glitches
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            termOn <= 1'b0;
        end
        else
        begin
            termOn <= termOn_d;
        end
    end

endmodule : sso_out_select

//--- logic/sso_wait_timer.sv
// Run delay timer: flags the wait between a run command and the end of the
// configured delay. Assumes tick is a one-cycle pulse once per delay unit.
module sso_wait_timer
    import sso_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        runCmd,
    input  wire logic [15:0] delayUnits,
    output logic             waiting
);
    import sso_pkg::*;

    sso_wait_e   state_q;  // Timer state
    sso_wait_e   state_d;
    logic [15:0] cnt_q;    // Remaining delay units
    logic [15:0] cnt_d;

    // Next state; dropping the run command always ends the wait
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            SSO_IDLE:
            begin
                if (runCmd)
                begin
                    cnt_d   = delayUnits;
                    state_d = (delayUnits == 16'h0000) ? SSO_DONE : SSO_WAIT;
                end
            end
            SSO_WAIT:
            begin
                if (!runCmd)
                begin
                    state_d = SSO_IDLE;
                end
                else if (tick)
                begin
                    cnt_d = cnt_q - 16'h0001;
                    if (cnt_q == 16'h0001)
                    begin
                        state_d = SSO_DONE;
                    end
                end
            end
            SSO_DONE:
            begin
                if (!runCmd)
                begin
                    state_d = SSO_IDLE;
                end
            end
            default:
            begin
                state_d = SSO_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= SSO_IDLE;
            cnt_q   <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // First partial tick may shorten the wait by under one unit
    assign waiting = (state_q == SSO_WAIT);

endmodule : sso_wait_timer

//--- logic/sso_status_output.sv
// Status output selector: two function-coded digital outputs driven from
// drive status conditions, plus heatsink trip and pre-alarm logic.
// Assumes all inputs are synchronous to clk_sys; settings come from the
// parameter store through the config write strobe.
module sso_status_output
    import sso_pkg::*;
#(
    parameter int unsigned TICK_LEN = sso_pkg::TICK_CYCLES  // Cycles per delay unit
)
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire sso_pkg::sso_status_s      drvStatus,
    input  wire logic [15:0]               outputFreq,
    input  wire logic [15:0]               zero_speed_threshold,
    input  wire logic [7:0]                heatsinkTemp,
    input  wire logic [7:0]                overheat_prealarm_level,
    input  wire logic [1:0]                overheat_prealarm_action,
    input  wire logic [15:0]               run_delay_time,
    input  wire logic                      cfgWe,
    input  wire logic                      cfgSelB,
    input  wire logic [sso_pkg::SEL_W-1:0] cfgWdata,
    output logic [sso_pkg::SEL_W-1:0]      output_a_function_select,
    output logic [sso_pkg::SEL_W-1:0]      output_b_function_select,
    output logic                           output_a_terminals,
    output logic                           output_b_terminals,
    output logic                           heatsink_overheat_fault,
    output logic [1:0]                     prealarmReaction
);
    import sso_pkg::*;

    logic [SEL_W-1:0]  selA_d;      // Next select A
    logic [SEL_W-1:0]  selB_d;      // Next select B
    logic [15:0]       div_q;       // Delay unit divider
    logic [15:0]       div_d;
    logic              tick;        // One pulse per delay unit
    logic              ohTrip_d;    // Next trip state
    logic [1:0]        react_d;     // Next pre-alarm reaction
    logic              preAlarm;    // Heatsink at pre-alarm level
    logic              waitActive;  // Run-wait window open
    logic [COND_N-1:0] condVec;     // Condition per function code
    logic              cfgTake;     // Config write accepted

    // Setting writes are taken only in range and while stopped, since the
    // selects may not change during operation
    // range check
    always_comb
    begin
        cfgTake = cfgWe && ssoCodeOk(cfgWdata) && !drvStatus.runCmd;
        selA_d  = output_a_function_select;
        selB_d  = output_b_function_select;
        if (cfgTake && !cfgSelB)
        begin
            selA_d = cfgWdata;
        end
        if (cfgTake && cfgSelB)
        begin
            selB_d = cfgWdata;
        end
    end

    // Select registers with their defaults
    // reset defaults
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_a_function_select <= RST_SEL_A;
            output_b_function_select <= RST_SEL_B;
        end
        else
        begin
            output_a_function_select <= selA_d;
            output_b_function_select <= selB_d;
        end
    end

    // Delay unit divider; the count is long so the length is a parameter
    always_comb
    begin
        tick  = (div_q == 16'(TICK_LEN - 1));
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
    end

    // Divider register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q <= 16'h0000;
        end
        else
        begin
            div_q <= div_d;
        end
    end

    // Run delay window
    // wait timer
    sso_wait_timer uWait (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .tick       (tick),
        .runCmd     (drvStatus.runCmd),
        .delayUnits (run_delay_time),
        .waiting    (waitActive)
    );

    // Heatsink trip is sticky until a fault reset; a hot reading in the
    // reset cycle wins so a trip is never lost
    always_comb
    begin
        preAlarm = (heatsinkTemp >= overheat_prealarm_level);
        ohTrip_d = (heatsinkTemp >= OH_TRIP_DEGC)
                 || (heatsink_overheat_fault && !drvStatus.faultResetIn);
        react_d  = preAlarm ? overheat_prealarm_action : 2'b00;
    end

    // Trip and reaction registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            heatsink_overheat_fault <= 1'b0;
            prealarmReaction        <= 2'b00;
        end
        else
        begin
            heatsink_overheat_fault <= ohTrip_d;
            prealarmReaction        <= react_d;
        end
    end

    // Condition vector indexed by function code
    always_comb
    begin
        condVec = '0;
        condVec[FN_RUN[5:0]]    = drvStatus.runCmd && drvStatus.outVoltage;
        condVec[FN_ZERO[5:0]]   = (outputFreq < zero_speed_threshold);
        condVec[FN_READY[5:0]]  = drvStatus.initDone && !drvStatus.faultAny;
        condVec[FN_UNDERV[5:0]] = drvStatus.underVolt;
        condVec[FN_BLOCK[5:0]]  = drvStatus.outBlocked;
        condVec[FN_REFSRC[5:0]] = drvStatus.keypadRefSel;
        condVec[FN_RUNSRC[5:0]] = drvStatus.keypadRunSel;
        condVec[FN_FAULT[5:0]]  = drvStatus.faultAny && !drvStatus.commFaultA
                                && !drvStatus.commFaultB;
        condVec[FN_ALARM[5:0]]  = drvStatus.alarm;
        condVec[FN_FRESET[5:0]] = drvStatus.faultResetIn;
        condVec[FN_REV[5:0]]    = drvStatus.reverse;
        condVec[FN_OHPRE[5:0]]  = preAlarm;
        condVec[FN_RUN2[5:0]]   = (outputFreq != 16'h0000) && !drvStatus.outBlocked
                                && !drvStatus.dcInject;
        condVec[FN_ENA[5:0]]    = drvStatus.enabled;
        condVec[FN_WAIT[5:0]]   = waitActive;
        condVec[FN_OHRED[5:0]]  = preAlarm && drvStatus.reducedFreq;
        condVec[FN_NETRUN[5:0]] = drvStatus.serialRun || drvStatus.optionRun;
        condVec[FN_FAN[5:0]]    = drvStatus.fanFault;
    end

    // Output terminal pairs
    // registered selection
    sso_out_select uOutA (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .funcSel (output_a_function_select),
        .condVec (condVec),
        .termOn  (output_a_terminals)
    );

    // Second output pair
    sso_out_select uOutB (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .funcSel (output_b_function_select),
        .condVec (condVec),
        .termOn  (output_b_terminals)
    );

    // Checks
    sequence seqRunRise;
        !drvStatus.runCmd ##1 drvStatus.runCmd;
    endsequence

    sequence seqWaitSeen;
        seqRunRise ##0 (run_delay_time != 16'h0000);
    endsequence

    sel_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ssoCodeOk(output_a_function_select) && ssoCodeOk(output_b_function_select))
        else $error("function select out of range");

    run_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_a_function_select == FN_RUN && $stable(output_a_function_select)
         && drvStatus.runCmd && drvStatus.outVoltage) |=> output_a_terminals)
        else $error("run output not on");

    run2_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_b_function_select == FN_RUN2 && $stable(output_b_function_select)
         && (drvStatus.outBlocked || drvStatus.dcInject)) |=> !output_b_terminals)
        else $error("run2 output on while not producing frequency");

    zero_speed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_b_function_select == FN_ZERO && $stable(output_b_function_select))
        |=> (output_b_terminals == $past(outputFreq < zero_speed_threshold)))
        else $error("zero speed output wrong");

    fault_comm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_a_function_select == FN_FAULT && $stable(output_a_function_select)
         && drvStatus.commFaultA) |=> !output_a_terminals)
        else $error("fault output on for comm fault");

    trip_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (heatsinkTemp >= OH_TRIP_DEGC) |=> heatsink_overheat_fault [*1]
        ##0 (heatsink_overheat_fault || !$past(drvStatus.faultResetIn)))
        else $error("overheat trip missed");

    wait_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (seqWaitSeen ##0 !waitActive && $past(uWait.state_q) == SSO_IDLE)
        |=> waitActive)
        else $error("run wait did not start");

    net_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_b_function_select == FN_NETRUN && $stable(output_b_function_select)
         && !drvStatus.serialRun && !drvStatus.optionRun) |=> !output_b_terminals)
        else $error("network run output on with both off");

    undef_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_a_function_select == 8'h02 && $stable(output_a_function_select))
        |=> !output_a_terminals)
        else $error("undefined code drives output");

    latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $stable(output_a_function_select)
        |=> (output_a_terminals == $past(condVec[output_a_function_select[5:0]])))
        else $error("output latency not one cycle");

endmodule : sso_status_output

//--- verif/sso_contact_reader.sv
// Model of the external equipment that reads the two output contacts.
// Assumes the contacts are plain levels, synchronous to clk_sys.
module sso_contact_reader
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       contactA,
    input  wire logic       contactB,
    output logic [7:0]      closeCntA,
    output logic [7:0]      closeCntB
);
    timeunit 1ns;
    timeprecision 1ps;

    logic prevA_q;  // Contact A at last edge
    logic prevB_q;  // Contact B at last edge

    // Count closures like a counter input would; short glitches still count
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevA_q   <= 1'b0;
            prevB_q   <= 1'b0;
            closeCntA <= 8'h00;
            closeCntB <= 8'h00;
        end
        else
        begin
            prevA_q <= contactA;
            prevB_q <= contactB;
            // Open to closed edges only
            if (contactA && !prevA_q)
                closeCntA <= closeCntA + 8'h01;
            if (contactB && !prevB_q)
                closeCntB <= closeCntB + 8'h01;
        end
    end
endmodule : sso_contact_reader

//--- verif/tb_status_output_selector.sv
// Self-checking bench for the status output selector.
// Assumes the design package is compiled first and the reader model is present.
module tb_status_output_selector
    import sso_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned TICK_SIM = 4;  // Short delay unit keeps the run brief

    // Table row: code, status, frequency, expected contact state
    localparam logic [43:0] ROWS [27] = '{
        {8'h00, 19'h60000, 16'h000A, 1'b1},
        {8'h00, 19'h40000, 16'h000A, 1'b0},
        {8'h37, 19'h00000, 16'h0032, 1'b1},
        {8'h37, 19'h00000, 16'h0000, 1'b0},
        {8'h37, 19'h08000, 16'h0032, 1'b0},
        {8'h37, 19'h10000, 16'h0032, 1'b0},
        {8'h01, 19'h00000, 16'h0009, 1'b1},
        {8'h01, 19'h00000, 16'h000A, 1'b0},
        {8'h06, 19'h04000, 16'h000A, 1'b1},
        {8'h06, 19'h06000, 16'h000A, 1'b0},
        {8'h07, 19'h00200, 16'h000A, 1'b1},
        {8'h08, 19'h08000, 16'h000A, 1'b1},
        {8'h09, 19'h00100, 16'h000A, 1'b1},
        {8'h0A, 19'h00080, 16'h000A, 1'b1},
        {8'h0E, 19'h02000, 16'h000A, 1'b1},
        {8'h0E, 19'h03000, 16'h000A, 1'b0},
        {8'h0E, 19'h02800, 16'h000A, 1'b0},
        {8'h0E, 19'h00400, 16'h000A, 1'b0},
        {8'h10, 19'h00400, 16'h000A, 1'b1},
        {8'h11, 19'h00040, 16'h000A, 1'b1},
        {8'h1A, 19'h00020, 16'h000A, 1'b1},
        {8'h38, 19'h00010, 16'h000A, 1'b1},
        {8'h3B, 19'h00004, 16'h000A, 1'b1},
        {8'h3B, 19'h00002, 16'h000A, 1'b1},
        {8'h3D, 19'h00001, 16'h000A, 1'b1},
        {8'h02, 19'h7FFFF, 16'h000A, 1'b0},
        {8'h3C, 19'h7FFFF, 16'h000A, 1'b0}
    };

    logic         clk_sys = 1'b0;        // System clock
    logic         rst_n = 1'b0;          // Reset, active low
    sso_status_s  drvStatus = '0;        // Status conditions
    logic [15:0]  outputFreq = 16'h000A; // Output frequency
    logic [15:0]  zero_speed_threshold = 16'h000A;
    logic [7:0]   heatsinkTemp = 8'h19;  // Cool heatsink
    logic [7:0]   overheat_prealarm_level = 8'h50;
    logic [1:0]   overheat_prealarm_action = 2'h2;
    logic [15:0]  run_delay_time = 16'h0002;
    logic         cfgWe = 1'b0;          // Config write strobe
    logic         cfgSelB = 1'b0;        // Config target select
    logic [7:0]   cfgWdata = 8'h00;      // Config code
    logic [7:0]   selA;                  // Select A readback
    logic [7:0]   selB;                  // Select B readback
    logic         termA;                 // Contact A
    logic         termB;                 // Contact B
    logic         tripFlag;              // Heatsink trip
    logic [1:0]   reaction;              // Pre-alarm reaction
    logic [7:0]   closeCntA;             // Closures seen on A
    logic [7:0]   closeCntB;             // Closures seen on B
    int           failures = 0;          // Mismatch count
    int           n_compared = 0;        // Comparison count
    int           cycles = 0;            // Watchdog count

    sso_status_output #(.TICK_LEN(TICK_SIM)) dut_u (
        .clk_sys                  (clk_sys),
        .rst_n                    (rst_n),
        .drvStatus                (drvStatus),
        .outputFreq               (outputFreq),
        .zero_speed_threshold     (zero_speed_threshold),
        .heatsinkTemp             (heatsinkTemp),
        .overheat_prealarm_level  (overheat_prealarm_level),
        .overheat_prealarm_action (overheat_prealarm_action),
        .run_delay_time           (run_delay_time),
        .cfgWe                    (cfgWe),
        .cfgSelB                  (cfgSelB),
        .cfgWdata                 (cfgWdata),
        .output_a_function_select (selA),
        .output_b_function_select (selB),
        .output_a_terminals       (termA),
        .output_b_terminals       (termB),
        .heatsink_overheat_fault  (tripFlag),
        .prealarmReaction         (reaction)
    );

    sso_contact_reader reader_u (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .contactA  (termA),
        .contactB  (termB),
        .closeCntA (closeCntA),
        .closeCntB (closeCntB)
    );

    // Clock generator, 20 ns period
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // Compare and report one value
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : check

    // One config write; strobe held for exactly one taken edge
    task automatic cfgWrite(input logic selTgt, input logic [7:0] code);
        cfgWe <= 1'b1;
        cfgSelB <= selTgt;
        cfgWdata <= code;
        @(posedge clk_sys);
        cfgWe <= 1'b0;
        @(posedge clk_sys);
    endtask : cfgWrite

    // Wait edges, then let their updates land
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    // Summary and verdict
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // Watchdog: the whole sequence needs well under 3000 cycles
    initial
    begin
        forever
        begin
            @(posedge clk_sys);
            cycles++;
            if (cycles >= 3000)
            begin
                failures++;
                test_done();
            end
        end
    end

    // Main sequence
    initial
    begin
        int   onCnt;
        logic [7:0] cnt0;
        logic [7:0] cnt0B;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(1);
        check(selA, RST_SEL_A);
        check(selB, RST_SEL_B);
        @(posedge clk_sys);
        cfgWrite(1'b0, 8'h3D);
        check(selA, 8'h3D);
        cfgWrite(1'b0, 8'h3E);
        check(selA, 8'h3D);
        drvStatus <= 19'h40000;
        cfgWrite(1'b1, 8'h0E);
        check(selB, 8'h01);
        drvStatus <= '0;
        cfgWrite(1'b1, 8'h0E);
        check(selB, 8'h0E);
        foreach (ROWS[i])
        begin
            drvStatus <= '0;
            outputFreq <= 16'h000A;
            cfgWrite(1'b0, ROWS[i][43:36]);
            cfgWrite(1'b1, ROWS[i][43:36]);
            @(posedge clk_sys);
            drvStatus <= ROWS[i][35:17];
            outputFreq <= ROWS[i][16:1];
            // Idle conditions still show until the next edge; only code 37 is on at idle
            #1;
            check(termA, ROWS[i][43:36] == FN_RUN2);
            settle(1);
            check(termA, ROWS[i][0]);
            check(termB, ROWS[i][0]);
            @(posedge clk_sys);
        end
        drvStatus <= '0;
        heatsinkTemp <= 8'h4F;
        cfgWrite(1'b0, FN_OHPRE);
        cfgWrite(1'b1, FN_OHRED);
        settle(2);
        check(termA, 1'b0);
        check(reaction, 2'h0);
        @(posedge clk_sys);
        heatsinkTemp <= 8'h50;
        settle(2);
        check(termA, 1'b1);
        check(termB, 1'b0);
        check(reaction, 2'h2);
        @(posedge clk_sys);
        drvStatus <= 19'h00008;
        settle(2);
        check(termB, 1'b1);
        // trip threshold, hot reading beats reset
        @(posedge clk_sys);
        drvStatus <= '0;
        heatsinkTemp <= 8'h68;
        settle(2);
        check(tripFlag, 1'b0);
        @(posedge clk_sys);
        heatsinkTemp <= OH_TRIP_DEGC;
        settle(1);
        check(tripFlag, 1'b1);
        @(posedge clk_sys);
        drvStatus <= 19'h00040;
        settle(2);
        check(tripFlag, 1'b1);
        @(posedge clk_sys);
        heatsinkTemp <= 8'h5A;
        settle(2);
        check(tripFlag, 1'b0);
        // run wait window of two delay units
        @(posedge clk_sys);
        drvStatus <= '0;
        heatsinkTemp <= 8'h19;
        cfgWrite(1'b0, FN_WAIT);
        cfgWrite(1'b1, FN_WAIT);
        cnt0 = closeCntA;
        cnt0B = closeCntB;
        drvStatus <= 19'h40000;
        onCnt = 0;
        repeat (16)
        begin
            settle(1);
            if (termA === 1'b1)
                onCnt++;
        end
        check(onCnt >= TICK_SIM + 1 && onCnt <= 2 * TICK_SIM, 1'b1);
        check(closeCntA - cnt0, 8'h01);
        check(closeCntB - cnt0B, 8'h01);
        // Zero delay never opens the window
        @(posedge clk_sys);
        drvStatus <= '0;
        run_delay_time <= 16'h0000;
        settle(2);
        @(posedge clk_sys);
        drvStatus <= 19'h40000;
        onCnt = 0;
        repeat (12)
        begin
            settle(1);
            if (termA !== 1'b0)
                onCnt++;
        end
        check(onCnt, 16'h0000);
        // Mid-run reset returns both selects to their defaults
        @(posedge clk_sys);
        rst_n <= 1'b0;
        settle(2);
        check(selA, RST_SEL_A);
        check(selB, RST_SEL_B);
        check(termA, 1'b0);
        check(termB, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(2);
        check(selA, RST_SEL_A);
        test_done();
    end
endmodule : tb_status_output_selector
